// File: cmi_pkg.sv
// Shared constants and types of the coprocessor-mode interface
`default_nettype none
package cmi_pkg;
  localparam int CMI_ADDR_W = 8;
  localparam logic [7:0] CMI_REG_CONFIG = 8'h00;
  localparam logic [7:0] CMI_REG_STATUS = 8'h04;
  localparam logic [7:0] CMI_REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] CMI_REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] CMI_REG_LAST_CMD = 8'h10;
  localparam logic [7:0] CMI_REG_LAST_EXT = 8'h14;
  localparam logic [1:0] CMI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMI_RESP_SLVERR = 2'h2;

  // Config word, bits 4..0: upper pipe, lower pipe, ieee, alu mask, mult mask
  typedef struct packed {
    logic [1:0] pipe;
    logic ieee;
    logic alu_inexact_mask;
    logic mult_inexact_mask;
  } cmi_cfg_t;
  localparam int CMI_CFG_W = 5;
  localparam cmi_cfg_t CMI_CFG_RESET = '{pipe: 2'h2, ieee: 1'b0, alu_inexact_mask: 1'b1, mult_inexact_mask: 1'b1};
  localparam logic [1:0] CMI_PIPE_COMPLEX = 2'h3;

  // Command word layout on the local bus
  localparam int CMI_CMD_ID_LSB = 29;
  localparam int CMI_CMD_TAG_W = 4;
  localparam int CMI_OP_LSB = 4;
  localparam int CMI_OP_W = 8;
  localparam int CMI_OP_EXT_BIT = 12;
  localparam int CMI_OP_CPLX_BIT = 13;
  localparam int CMI_OP_MULT_INEX_BIT = 14;
  localparam int CMI_OP_ALU_INEX_BIT = 15;
  localparam int CMI_EXT_RET_BIT = 31;
  localparam logic [7:0] CMI_OP_WRAP = 8'h5a;
  localparam logic [7:0] CMI_OP_UNWRAP = 8'h5b;
  localparam int CMI_EXEC_BASE = 4;

  // Sticky event bits
  localparam int CMI_EV_W = 6;
  localparam int CMI_EV_DONE = 0;
  localparam int CMI_EV_OVERLAP = 1;
  localparam int CMI_EV_DENORM = 2;
  localparam int CMI_EV_INEXACT = 3;
  localparam int CMI_EV_BUS_FAULT = 4;
  localparam int CMI_EV_HOSTIRQ = 5;

  localparam logic [1:0] CMI_EC_LOW = 2'h0;
  localparam logic [1:0] CMI_EC_HIGH = 2'h1;
  localparam logic [1:0] CMI_EC_NORMAL = 2'h3;

  typedef enum logic [1:0] {CMI_IDLE, CMI_EXEC_INT, CMI_EXEC_EXT} cmi_state_t;

  // Host pins after synchronisation
  typedef struct packed {
    logic pclk;
    logic sclk;
    logic ready;
    logic alatch_n;
    logic spec_fn;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bus_fault;
    logic out_en_n;
    logic irq_req_n;
    logic strap;
    logic [2:0] cid;
    logic [1:0] ec;
    logic [31:0] lad;
    logic [31:0] mem_data;
  } cmi_pins_t;
  localparam cmi_pins_t CMI_PINS_IDLE = '{pclk: 1'b0, sclk: 1'b0, ready: 1'b1, alatch_n: 1'b1, spec_fn: 1'b0,
    ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bus_fault: 1'b0, out_en_n: 1'b0, irq_req_n: 1'b1, strap: 1'b0,
    cid: 3'h0, ec: 2'h3, lad: 32'h0, mem_data: 32'h0};
endpackage : cmi_pkg
`default_nettype wire

// File: cmi_pin_sync.sv
// Three-stage synchroniser with agreement filter for host pins
`default_nettype none
module cmi_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } cmi_sync_state_t;

  cmi_sync_state_t s;
  cmi_sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // A bit moves only once stages two and three agree
    next_s.stable = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.stable);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, stable: RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.stable;
endmodule : cmi_pin_sync
`default_nettype wire

// File: cmi_coproc.sv
// Coprocessor-mode front end with AXI4-Lite register access
`default_nettype none
module cmi_coproc
  import cmi_pkg::*;
#(
  parameter int EXEC_BASE = CMI_EXEC_BASE
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [CMI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [CMI_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic irq_out,
  input wire logic primary_local_clock_in,
  input wire logic secondary_local_clock_in,
  input wire logic local_ready_in,
  input wire logic address_latch_strobe_n_in,
  input wire logic special_function_in,
  input wire logic row_strobe_n_in,
  input wire logic column_strobe_n_in,
  input wire logic write_enable_n_in,
  input wire logic bus_fault_in,
  input wire logic local_output_enable_n_in,
  input wire logic interrupt_request_n_in,
  input wire logic host_select_strap_in,
  input wire logic [2:0] coproc_id_strap_in,
  input wire logic [1:0] emulation_control_pins_in,
  input wire logic [31:0] local_addr_data_bus_in,
  input wire logic [31:0] memory_side_data_port_in,
  output logic coproc_interrupt_n_out,
  output logic coproc_ready_out
);
  typedef struct packed {
    cmi_state_t state;
    cmi_cfg_t cfg;
    logic [CMI_EV_W-1:0] irq_stat;
    logic [CMI_EV_W-1:0] irq_mask;
    logic irq_q;
    logic pclk_q;
    logic sclk_q;
    logic alatch_q;
    logic next_valid;
    logic [31:0] next_word;
    logic [31:0] cur_word;
    logic [31:0] ext_word;
    logic cplx_active;
    logic [7:0] count;
    logic [CMI_ADDR_W-1:0] awaddr;
    logic aw_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cmi_core_t;

  cmi_core_t s;
  cmi_core_t next_s;
  cmi_pins_t pins_raw;
  cmi_pins_t p;

  // Instruction length grows by one per pipe bit that is clear
  function automatic logic [7:0] cmi_exec_len(input logic [1:0] pipe);
    cmi_exec_len = 8'(EXEC_BASE) + {7'h0, ~pipe[1]} + {7'h0, ~pipe[0]};
  endfunction : cmi_exec_len

  function automatic logic [31:0] cmi_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    cmi_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        cmi_merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction : cmi_merge

  function automatic logic cmi_mapped(input logic [CMI_ADDR_W-1:0] a);
    cmi_mapped = (a == CMI_REG_CONFIG) || (a == CMI_REG_STATUS) || (a == CMI_REG_IRQ_STATUS) ||
                 (a == CMI_REG_IRQ_MASK) || (a == CMI_REG_LAST_CMD) || (a == CMI_REG_LAST_EXT);
  endfunction : cmi_mapped

  assign pins_raw = '{pclk: primary_local_clock_in, sclk: secondary_local_clock_in,
    ready: local_ready_in, alatch_n: address_latch_strobe_n_in, spec_fn: special_function_in,
    ras_n: row_strobe_n_in, cas_n: column_strobe_n_in, we_n: write_enable_n_in,
    bus_fault: bus_fault_in, out_en_n: local_output_enable_n_in, irq_req_n: interrupt_request_n_in,
    strap: host_select_strap_in, cid: coproc_id_strap_in, ec: emulation_control_pins_in,
    lad: local_addr_data_bus_in, mem_data: memory_side_data_port_in};

  // All host pins come from another domain; one synchroniser covers them
  cmi_pin_sync #(
    .WIDTH($bits(cmi_pins_t)),
    .RESET_VAL(CMI_PINS_IDLE)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(pins_raw),
    .q_out(p)
  );

  logic coproc_mode;
  logic ec_normal;
  logic busy;
  logic tick;
  logic cmd_strobe;
  logic [1:0] eff_pipe;
  logic [7:0] opcode;
  logic [CMI_EV_W-1:0] events;
  logic [CMI_EV_W-1:0] w1c;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic ready_int;

  always_comb begin
    coproc_mode = ~p.strap;
    ec_normal = (p.ec == CMI_EC_NORMAL);
    busy = (s.state != CMI_IDLE);
    // Each level change of the primary clock is one internal edge, unless stalled
    tick = (p.pclk != s.pclk_q) && p.ready;
    // Command: our id, low tag clear, row strobe high, SF high at latch fall
    cmd_strobe = s.alatch_q && !p.alatch_n && p.spec_fn && p.ras_n && coproc_mode && ec_normal &&
                 (p.lad[CMI_CMD_TAG_W-1:0] == '0) &&
                 (p.lad[CMI_CMD_ID_LSB +: 3] == p.cid);
    eff_pipe = s.cplx_active ? CMI_PIPE_COMPLEX : s.cfg.pipe;
    opcode = s.next_word[CMI_OP_LSB +: CMI_OP_W];
    ready_int = !(s.next_valid && busy);
    status_word = '0;
    status_word[0] = busy;
    status_word[1] = s.next_valid;
    status_word[2] = ready_int;
    status_word[3] = coproc_mode;
    status_word[5:4] = eff_pipe;
    status_word[6] = ~eff_pipe[1];
    status_word[7] = s.cplx_active;
    status_word[10:8] = p.cid;
    status_word[11] = p.out_en_n;
    status_word[12] = p.cas_n;
    status_word[13] = p.we_n;
    status_word[15:14] = p.ec;
    case (s_axi_araddr_in)
      CMI_REG_CONFIG: rd_word = {{(32-CMI_CFG_W){1'b0}}, s.cfg};
      CMI_REG_STATUS: rd_word = status_word;
      CMI_REG_IRQ_STATUS: rd_word = {{(32-CMI_EV_W){1'b0}}, s.irq_stat};
      CMI_REG_IRQ_MASK: rd_word = {{(32-CMI_EV_W){1'b0}}, s.irq_mask};
      CMI_REG_LAST_CMD: rd_word = s.cur_word;
      CMI_REG_LAST_EXT: rd_word = s.ext_word;
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    next_s = s;
    events = '0;
    w1c = '0;
    next_s.pclk_q = p.pclk;
    next_s.sclk_q = p.sclk;
    next_s.alatch_q = p.alatch_n;

    // Secondary clock only samples the interrupt request line
    if (p.sclk && !s.sclk_q && !p.irq_req_n) begin
      events[CMI_EV_HOSTIRQ] = 1'b1;
    end

    // Latch a command even while stalled; host keeps it on the bus anyway
    if (cmd_strobe && !s.next_valid) begin
      next_s.next_valid = 1'b1;
      next_s.next_word = p.lad;
      if (busy) begin
        events[CMI_EV_OVERLAP] = 1'b1;
      end
    end

    if (tick) begin
      if (busy && p.bus_fault) begin
        // Fault with ready high ends the instruction; retry never reaches here
        events[CMI_EV_BUS_FAULT] = 1'b1;
        next_s.state = CMI_IDLE;
        next_s.cplx_active = 1'b0;
      end else begin
        case (s.state)
          CMI_IDLE: begin
            // No fetch of its own: only a latched host command starts work
            if (s.next_valid) begin
              next_s.next_valid = 1'b0;
              next_s.cur_word = s.next_word;
              if (s.next_word[CMI_OP_EXT_BIT]) begin
                next_s.state = CMI_EXEC_EXT;
              end else if (s.cfg.ieee && ((opcode == CMI_OP_WRAP) || (opcode == CMI_OP_UNWRAP))) begin
                // IEEE denormal wrapping has no internal form
                events[CMI_EV_DENORM] = 1'b1;
                events[CMI_EV_DONE] = 1'b1;
              end else if (s.next_word[CMI_OP_CPLX_BIT]) begin
                next_s.cplx_active = 1'b1;
                next_s.count = cmi_exec_len(CMI_PIPE_COMPLEX);
                next_s.state = CMI_EXEC_INT;
              end else begin
                next_s.count = cmi_exec_len(s.cfg.pipe);
                next_s.state = CMI_EXEC_INT;
              end
            end
          end
          CMI_EXEC_INT: begin
            if (s.count <= 8'h1) begin
              next_s.state = CMI_IDLE;
              next_s.cplx_active = 1'b0;
              events[CMI_EV_DONE] = 1'b1;
              events[CMI_EV_INEXACT] = (s.cur_word[CMI_OP_MULT_INEX_BIT] && s.cfg.mult_inexact_mask) ||
                                       (s.cur_word[CMI_OP_ALU_INEX_BIT] && s.cfg.alu_inexact_mask);
            end else begin
              next_s.count = s.count - 8'h1;
            end
          end
          CMI_EXEC_EXT: begin
            // External code streams in over the memory-side port
            next_s.ext_word = p.mem_data;
            if (p.mem_data[CMI_EXT_RET_BIT]) begin
              next_s.state = CMI_IDLE;
              events[CMI_EV_DONE] = 1'b1;
            end
          end
          default: begin
            next_s.state = CMI_IDLE;
          end
        endcase
      end
    end

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_s.awaddr = s_axi_awaddr_in;
      next_s.aw_full = 1'b1;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_s.wdata = s_axi_wdata_in;
      next_s.wstrb = s_axi_wstrb_in;
      next_s.w_full = 1'b1;
    end
    if (s.aw_full && s.w_full) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = cmi_mapped(s.awaddr) ? CMI_RESP_OKAY : CMI_RESP_SLVERR;
      case (s.awaddr)
        CMI_REG_CONFIG: next_s.cfg = cmi_cfg_t'(CMI_CFG_W'(cmi_merge({{(32-CMI_CFG_W){1'b0}}, s.cfg}, s.wdata,
                                                                     s.wstrb)));
        CMI_REG_IRQ_STATUS: w1c = CMI_EV_W'(cmi_merge('0, s.wdata, s.wstrb));
        CMI_REG_IRQ_MASK: next_s.irq_mask = CMI_EV_W'(cmi_merge({{(32-CMI_EV_W){1'b0}}, s.irq_mask},
                                                                s.wdata, s.wstrb));
        default: begin
        end
      endcase
    end
    if (s.bvalid && s_axi_bready_in) begin
      next_s.bvalid = 1'b0;
    end

    // AXI4-Lite read: one cycle from address to data
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = cmi_mapped(s_axi_araddr_in) ? CMI_RESP_OKAY : CMI_RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready_in) begin
      next_s.rvalid = 1'b0;
    end

    // Set wins over a same-cycle clear
    next_s.irq_stat = (s.irq_stat & ~w1c) | events;
    next_s.irq_q = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Config returns to defaults, pin-edge flops take idle pin levels (alatch_q loads 1), all other state flops clear
      s <= '0;
      s.state <= CMI_IDLE;
      s.cfg <= CMI_CFG_RESET;
      s.pclk_q <= CMI_PINS_IDLE.pclk;
      s.sclk_q <= CMI_PINS_IDLE.sclk;
      s.alatch_q <= CMI_PINS_IDLE.alatch_n;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    s_axi_awready_out = !s.aw_full && !s.bvalid;
    s_axi_wready_out = !s.w_full && !s.bvalid;
    s_axi_bvalid_out = s.bvalid;
    s_axi_bresp_out = s.bresp;
    s_axi_arready_out = !s.rvalid;
    s_axi_rvalid_out = s.rvalid;
    s_axi_rdata_out = s.rdata;
    s_axi_rresp_out = s.rresp;
    irq_out = s.irq_q;
    // Only these two host signals are driven; emulation pins can force them
    case (p.ec)
      CMI_EC_LOW: begin
        coproc_interrupt_n_out = 1'b0;
        coproc_ready_out = 1'b0;
      end
      CMI_EC_HIGH: begin
        coproc_interrupt_n_out = 1'b1;
        coproc_ready_out = 1'b1;
      end
      default: begin
        coproc_interrupt_n_out = !s.irq_q;
        coproc_ready_out = ready_int || !coproc_mode;
      end
    endcase
  end
endmodule : cmi_coproc
`default_nettype wire

// File: cmi_coproc_properties.sv
// Port-level checks of the coprocessor-mode interface
`default_nettype none
module cmi_coproc_checker
  import cmi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [CMI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic irq_out,
  input wire logic host_select_strap_in,
  input wire logic local_ready_in,
  input wire logic coproc_interrupt_n_out,
  input wire logic coproc_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_idle: assert property (disable iff (1'h0) rst_in |=> coproc_ready_out && coproc_interrupt_n_out)
    else $error("outputs not idle during reset");
  a_idle_after: assert property ($fell(rst_in) |-> (coproc_ready_out && !irq_out) [*4])
    else $error("not idle after reset release");
  a_int_level: assert property (coproc_interrupt_n_out == !irq_out)
    else $error("interrupt pin disagrees with irq level");
  a_strap_ready: assert property (host_select_strap_in [*6] |-> coproc_ready_out)
    else $error("ready low outside coprocessor mode");
  // Latching still works while stalled, so only a rise is forbidden
  a_stall_ready: assert property ((!local_ready_in) [*6] |-> !$rose(coproc_ready_out))
    else $error("ready rose while stalled");
  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  a_rd_lat: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_wr_lat: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out)
    else $error("write answer late");
  a_rd_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > CMI_REG_LAST_EXT
    |=> s_axi_rresp_out == CMI_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  c_irq: cover property ($rose(irq_out));
  c_busy_host: cover property ($fell(coproc_ready_out));
  c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == CMI_RESP_SLVERR);
endmodule : cmi_coproc_checker
bind cmi_coproc cmi_coproc_checker i_cmi_coproc_checker (.*);
`default_nettype wire

// File: cmi_host_model.sv
// Host-side model: local clock, ready combine, command issue
`default_nettype none
module cmi_host_model (
  input wire logic clk_in,
  input wire logic coproc_ready_in,
  input wire logic stall_in,
  output logic plclk_out,
  output logic latch_n_out,
  output logic special_fn_out,
  output logic ras_n_out,
  output logic [31:0] lad_out,
  output logic local_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div = 2'h0;
  logic sys_rdy = 1'h1;
  initial begin
    plclk_out = 1'h0;
    latch_n_out = 1'h1;
    special_fn_out = 1'h0;
    lad_out = 32'h0;
  end
  assign ras_n_out = 1'h1;
  assign local_ready_out = (coproc_ready_in | sys_rdy) & !stall_in;
  always @(posedge clk_in) begin
    div <= div + 2'h1;
    if (div == 2'h3) plclk_out <= !plclk_out;
  end
  task automatic cmd(input logic [31:0] w);
    @(posedge clk_in);
    lad_out <= w;
    special_fn_out <= 1'h1;
    repeat (2) @(posedge clk_in);
    latch_n_out <= 1'h0;
    repeat (8) @(posedge clk_in);
    latch_n_out <= 1'h1;
    special_fn_out <= 1'h0;
    // Released bus shows a changed pattern, not the old word
    lad_out <= ~w;
  endtask : cmd
endmodule : cmi_host_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the coprocessor-mode interface
`default_nettype none
module testbench;
  import cmi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0, rst_in = 1'h1, stall = 1'h0, secondary_local_clock_in = 1'h0;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, memory_side_data_port_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic column_strobe_n_in = 1'h1, write_enable_n_in = 1'h1, bus_fault_in = 1'h0;
  logic host_select_strap_in = 1'h0, local_output_enable_n_in = 1'h0, interrupt_request_n_in = 1'h1;
  logic [2:0] coproc_id_strap_in = 3'h0;
  logic [1:0] emulation_control_pins_in = 2'h3;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out, local_addr_data_bus_in;
  logic irq_out, coproc_interrupt_n_out, coproc_ready_out, primary_local_clock_in, local_ready_in;
  logic address_latch_strobe_n_in, special_function_in, row_strobe_n_in;
  int fails = 0, n_tests = 0;
  cmi_coproc i_cmi_coproc (.*);
  cmi_host_model i_cmi_host_model (.clk_in(clk_in), .coproc_ready_in(coproc_ready_out), .stall_in(stall),
    .plclk_out(primary_local_clock_in), .latch_n_out(address_latch_strobe_n_in),
    .special_fn_out(special_function_in), .ras_n_out(row_strobe_n_in), .lad_out(local_addr_data_bus_in),
    .local_ready_out(local_ready_in));
  always #20 clk_in = !clk_in;
  always #80 secondary_local_clock_in = !secondary_local_clock_in;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_bready_in <= 1'h1;
    fork
      begin do @(posedge clk_in); while (s_axi_awready_out !== 1'h1); s_axi_awvalid_in <= 1'h0; end
      begin do @(posedge clk_in); while (s_axi_wready_out !== 1'h1); s_axi_wvalid_in <= 1'h0; end
    join
    do @(posedge clk_in); while (s_axi_bvalid_out !== 1'h1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'h0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_arvalid_in <= 1'h1;
    s_axi_araddr_in <= a;
    s_axi_rready_in <= 1'h1;
    do @(posedge clk_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 1'h0;
    do @(posedge clk_in); while (s_axi_rvalid_out !== 1'h1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'h0;
    @(posedge clk_in);
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d & m, e);
    chk(nm, r, CMI_RESP_OKAY);
  endtask : rdc
  task automatic clr();
    logic [1:0] r;
    wr(CMI_REG_IRQ_STATUS, 32'h3f, r);
    repeat (2) @(posedge clk_in);
    chk("irq_cleared", irq_out, 1'h0);
  endtask : clr
  task automatic wirq();
    for (int i = 0; i < 300 && irq_out !== 1'h1; i++) @(posedge clk_in);
    chk("irq_out", irq_out, 1'h1);
    chk("int_pin", coproc_interrupt_n_out, 1'h0);
  endtask : wirq
  task automatic endt(input string s);
    $display("test %s done, mismatches %0d", s, fails);
  endtask : endt
  function automatic logic [31:0] cw(input logic [7:0] op, input logic ext, input logic cplx);
    return {18'h0, cplx, ext, op, 4'h0};
  endfunction : cw
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    fails++;
    finish_test();
  end
  initial begin
    logic [31:0] d, m;
    logic [1:0] r;
    void'($urandom(69697));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'h0;
    column_strobe_n_in <= 1'($urandom);
    write_enable_n_in <= 1'($urandom);
    repeat (6) @(posedge clk_in);
    chk("ready_reset", coproc_ready_out, 1'h1);
    rdc("config_reset", CMI_REG_CONFIG, 32'h1f, {27'h0, CMI_CFG_RESET});
    rdc("pipe_reset", CMI_REG_CONFIG, 32'h18, 32'h10);
    rdc("status_idle", CMI_REG_STATUS, 32'h300f, {18'h0, write_enable_n_in, column_strobe_n_in, 12'hc});
    rdc("irq_reset", CMI_REG_IRQ_STATUS, 32'h3f, 32'h0);
    endt("reset");
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(CMI_REG_CONFIG, d, r);
      rdc("config_rw", CMI_REG_CONFIG, 32'h1f, d & 32'h1f);
      wr(CMI_REG_IRQ_MASK, d >> 8, r);
      rdc("mask_rw", CMI_REG_IRQ_MASK, 32'h3f, (d >> 8) & 32'h3f);
    end
    rd(8'h40, d, r);
    chk("unmapped_rresp", r, CMI_RESP_SLVERR);
    wr(8'h40, 32'hffffffff, r);
    chk("unmapped_bresp", r, CMI_RESP_SLVERR);
    endt("registers");
    wr(CMI_REG_IRQ_MASK, 32'h3f, r);
    wr(CMI_REG_CONFIG, 32'h14, r);
    i_cmi_host_model.cmd(cw(CMI_OP_WRAP, 1'h0, 1'h0));
    wirq();
    rdc("denorm", CMI_REG_IRQ_STATUS, 32'h3f, 32'h1 << CMI_EV_DENORM | 32'h1 << CMI_EV_DONE);
    clr();
    endt("ieee");
    wr(CMI_REG_CONFIG, 32'h0, r);
    rdc("core_out", CMI_REG_STATUS, 32'h70, 32'h40);
    i_cmi_host_model.cmd(cw(8'($urandom), 1'h0, 1'h1));
    // Start waits for the next primary clock change
    repeat (2) @(posedge clk_in);
    rdc("cplx_pipe", CMI_REG_STATUS, 32'hb0, 32'hb0);
    wirq();
    rdc("pipe_back", CMI_REG_STATUS, 32'hb0, 32'h0);
    rdc("cfg_kept", CMI_REG_CONFIG, 32'h1f, 32'h0);
    clr();
    endt("complex");
    wr(CMI_REG_CONFIG, 32'h13, r);
    i_cmi_host_model.cmd(cw(8'h01, 1'h0, 1'h0));
    chk("ready_accept", coproc_ready_out, 1'h1);
    i_cmi_host_model.cmd(cw(8'h02, 1'h0, 1'h0));
    chk("ready_low", coproc_ready_out, 1'h0);
    for (int i = 0; i < 100 && coproc_ready_out !== 1'h1; i++) @(posedge clk_in);
    chk("ready_back", coproc_ready_out, 1'h1);
    wirq();
    rdc("overlap", CMI_REG_IRQ_STATUS, 32'h3, 32'h3);
    repeat (40) @(posedge clk_in);
    clr();
    endt("overlap");
    wr(CMI_REG_IRQ_MASK, 32'h0, r);
    i_cmi_host_model.cmd(cw(8'h03, 1'h0, 1'h0));
    stall <= 1'h1;
    repeat (40) @(posedge clk_in);
    rdc("stall_frozen", CMI_REG_IRQ_STATUS, 32'h1, 32'h0);
    stall <= 1'h0;
    repeat (60) @(posedge clk_in);
    rdc("resumed", CMI_REG_IRQ_STATUS, 32'h1, 32'h1);
    chk("masked", irq_out, 1'h0);
    clr();
    endt("stall");
    host_select_strap_in <= 1'h1;
    repeat (8) @(posedge clk_in);
    i_cmi_host_model.cmd(cw(8'h04, 1'h0, 1'h0));
    repeat (60) @(posedge clk_in);
    rdc("strap_mode", CMI_REG_STATUS, 32'h9, 32'h0);
    rdc("strap_ignored", CMI_REG_IRQ_STATUS, 32'h3f, 32'h0);
    host_select_strap_in <= 1'h0;
    repeat (8) @(posedge clk_in);
    endt("strap");
    interrupt_request_n_in <= 1'h0;
    repeat (20) @(posedge clk_in);
    interrupt_request_n_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    rdc("host_irq", CMI_REG_IRQ_STATUS, 32'h20, 32'h20);
    clr();
    endt("host_irq");
    d = $urandom | 32'h80000000;
    memory_side_data_port_in <= d;
    m = cw(8'($urandom), 1'h1, 1'h0);
    i_cmi_host_model.cmd(m);
    repeat (40) @(posedge clk_in);
    rdc("ext_word", CMI_REG_LAST_EXT, 32'hffffffff, d);
    rdc("cmd_word", CMI_REG_LAST_CMD, 32'hffffffff, m);
    endt("external");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
